/* File: rtl/pms_pkg.sv */
// Package for the PWM mode-control and shadow-update block.
// Assumes a single 250 MHz clock and a plain strobe register port.
package pms_pkg;

    localparam int PMS_ADDR_W = 8;
    localparam int PMS_DATA_W = 32;
    localparam int PMS_CNT_W  = 16;
    localparam int PMS_IRQ_W  = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_MODE     = 8'h00;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_CONFIG   = 8'h04;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_MIRROR   = 8'h08;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_ACTIVE   = 8'h0C;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_COUNT    = 8'h10;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_INT_STAT = 8'h14;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_INT_CLR  = 8'h18;
    localparam logic [PMS_ADDR_W-1:0] PMS_OFS_INT_EN   = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode-control field positions
    localparam int PMS_B_COUNTER_RUN   = 0;
    localparam int PMS_B_COUNTER_CLEAR = 1;
    localparam int PMS_B_SINGLE_CYCLE  = 2;
    localparam int PMS_B_SYNC_OUT_GATE = 3;
    localparam int PMS_B_SYNC_SOURCE   = 4;
    localparam int PMS_B_XFER_SOURCE   = 5;
    localparam int PMS_B_SW_TRANSFER   = 6;
    localparam int PMS_B_DOMAIN_SYNC   = 7;
    localparam int PMS_MODE_W          = 8;

    // Interrupt bit positions
    localparam int PMS_I_TRANSFER_DONE = 0;
    localparam int PMS_I_SYNC_DONE     = 1;
    localparam int PMS_I_CYCLE_END     = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [PMS_MODE_W-1:0] PMS_MODE_RST    = 8'h00;
    localparam logic [PMS_CNT_W-1:0]  PMS_PERIOD_RST  = 16'hFFFF;
    localparam logic [PMS_CNT_W-1:0]  PMS_PRESCL_RST  = 16'h0000;
    localparam logic [PMS_IRQ_W-1:0]  PMS_IRQ_RST     = 3'h0;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [PMS_ADDR_W-1:0] addr;
        logic [PMS_DATA_W-1:0] wdata;
    } pms_bus_req_type;

    typedef struct packed {
        logic [PMS_CNT_W-1:0] prescale;
        logic [PMS_CNT_W-1:0] period;
    } pms_cfg_type;

    typedef enum logic [1:0] {
        PMS_HS_IDLE = 2'b00,
        PMS_HS_REQ  = 2'b01,
        PMS_HS_DONE = 2'b10
    } pms_hs_state_type;

endpackage

/* File: rtl/pms_mode_shadow.sv */
// PWM mode control, counters, domain sync handshake and shadow transfer.
// Assumes one clock; sync and transfer-enable pins are asynchronous.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module pms_mode_shadow
    import pms_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire pms_bus_req_type       bus_req,
    output logic [PMS_DATA_W-1:0]      rd_data,
    input  wire logic                  sync_in_pin,
    input  wire logic                  trans_enable_pin,
    output logic                       sync_out,
    output logic                       irq,
    output logic [PMS_CNT_W-1:0]       pwm_count
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [PMS_MODE_W-1:0] mode_reg;
    logic [PMS_MODE_W-1:0] mode_next;
    pms_cfg_type           cfg_reg;
    pms_cfg_type           stage_reg;
    pms_cfg_type           active_reg;
    pms_hs_state_type      hs_state_reg;
    pms_hs_state_type      hs_state_next;
    logic                  hs_req_reg;
    logic                  hs_ack_reg;
    logic [1:0]            sync_pin_reg;
    logic [1:0]            xfer_pin_reg;
    logic [PMS_CNT_W-1:0]  presc_reg;
    logic [PMS_CNT_W-1:0]  count_reg;
    logic [PMS_IRQ_W-1:0]  int_stat_reg;
    logic [PMS_IRQ_W-1:0]  int_en_reg;
    logic [PMS_IRQ_W-1:0]  int_event;
    logic                  sync_out_reg;
    logic                  irq_reg;
    logic [PMS_DATA_W-1:0] rd_data_reg;

    logic                  wr_mode;
    logic                  wr_cfg;
    logic                  wr_int_clr;
    logic                  wr_int_en;
    logic                  run;
    logic                  hold_clear;
    logic                  presc_wrap;
    logic                  overflow;
    logic                  ext_restart;
    logic                  new_cycle;
    logic                  hw_source;
    logic                  load_trig;
    logic                  xfer_done;
    logic                  dsync_done;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    assign wr_mode    = bus_req.wr && (bus_req.addr == PMS_OFS_MODE);
    assign wr_cfg     = bus_req.wr && (bus_req.addr == PMS_OFS_CONFIG);
    assign wr_int_clr = bus_req.wr && (bus_req.addr == PMS_OFS_INT_CLR);
    assign wr_int_en  = bus_req.wr && (bus_req.addr == PMS_OFS_INT_EN);

    assign run        = mode_reg[PMS_B_COUNTER_RUN];
    assign hold_clear = mode_reg[PMS_B_COUNTER_CLEAR];

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_pin_reg <= 2'h0;
            xfer_pin_reg <= 2'h0;
        end else begin
            sync_pin_reg <= {sync_pin_reg[0], sync_in_pin};
            xfer_pin_reg <= {xfer_pin_reg[0], trans_enable_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle control

    assign presc_wrap  = run && !hold_clear && (presc_reg == active_reg.prescale);
    assign overflow    = presc_wrap && (count_reg == active_reg.period);
    assign ext_restart = mode_reg[PMS_B_SYNC_SOURCE] && sync_pin_reg[1];
    assign new_cycle   = overflow || ext_restart;

    // Prescale counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            presc_reg <= '0;
        end else if (hold_clear) begin
            presc_reg <= '0;
        end else if (run) begin
            if (presc_wrap || ext_restart) begin
                presc_reg <= '0;
            end else begin
                presc_reg <= presc_reg + {{(PMS_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // PWM counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (hold_clear) begin
            count_reg <= '0;
        end else if (run) begin
            if (new_cycle) begin
                count_reg <= '0;
            end else if (presc_wrap) begin
                count_reg <= count_reg + {{(PMS_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Sync output pulses at each new cycle when gated on
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_out_reg <= 1'b0;
        end else begin
            sync_out_reg <= mode_reg[PMS_B_SYNC_OUT_GATE] && new_cycle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode register: hardware clears lose against a software write

    always_comb begin
        mode_next = mode_reg;
        if (overflow && mode_reg[PMS_B_SINGLE_CYCLE]) begin
            mode_next[PMS_B_COUNTER_RUN] = 1'b0;
        end
        if (xfer_done) begin
            mode_next[PMS_B_SW_TRANSFER] = 1'b0;
        end
        if (dsync_done) begin
            mode_next[PMS_B_DOMAIN_SYNC] = 1'b0;
        end
        if (wr_mode) begin
            mode_next = bus_req.wdata[PMS_MODE_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_reg <= PMS_MODE_RST;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // System-side configuration, written by software at any time, whatever the sync state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_reg <= '{prescale: PMS_PRESCL_RST, period: PMS_PERIOD_RST};
        end else if (wr_cfg) begin
            cfg_reg <= bus_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Domain sync handshake, requesting side

    assign dsync_done = (hs_state_reg == PMS_HS_REQ) && hs_ack_reg;

    always_comb begin
        hs_state_next = hs_state_reg;
        case (hs_state_reg)
            PMS_HS_IDLE: begin
                if (mode_reg[PMS_B_DOMAIN_SYNC]) begin
                    hs_state_next = PMS_HS_REQ;
                end
            end
            PMS_HS_REQ: begin
                if (hs_ack_reg) begin
                    hs_state_next = PMS_HS_DONE;
                end
            end
            PMS_HS_DONE: begin
                if (!hs_ack_reg) begin
                    hs_state_next = PMS_HS_IDLE;
                end
            end
            default: begin
                hs_state_next = PMS_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hs_state_reg <= PMS_HS_IDLE;
            hs_req_reg   <= 1'b0;
        end else begin
            hs_state_reg <= hs_state_next;
            hs_req_reg   <= (hs_state_next == PMS_HS_REQ);
        end
    end

    // Domain sync handshake, PWM side: captures the whole set in one edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hs_ack_reg <= 1'b0;
            stage_reg  <= '{prescale: PMS_PRESCL_RST, period: PMS_PERIOD_RST};
        end else if (hs_req_reg && !hs_ack_reg) begin
            stage_reg  <= cfg_reg;
            hs_ack_reg <= 1'b1;
        end else if (!hs_req_reg) begin
            hs_ack_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow transfer

    assign hw_source = mode_reg[PMS_B_SYNC_SOURCE] && mode_reg[PMS_B_XFER_SOURCE];
    assign load_trig = hw_source ? xfer_pin_reg[1]
                                 : (mode_reg[PMS_B_SW_TRANSFER] && new_cycle);
    assign xfer_done = load_trig && !hw_source;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            active_reg <= '{prescale: PMS_PRESCL_RST, period: PMS_PERIOD_RST};
        end else if (load_trig) begin
            active_reg <= stage_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over clear

    assign int_event[PMS_I_TRANSFER_DONE] = xfer_done;
    assign int_event[PMS_I_SYNC_DONE]     = dsync_done;
    assign int_event[PMS_I_CYCLE_END]     = overflow;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            int_stat_reg <= PMS_IRQ_RST;
        end else if (wr_int_clr) begin
            int_stat_reg <= (int_stat_reg & ~bus_req.wdata[PMS_IRQ_W-1:0]) | int_event;
        end else begin
            int_stat_reg <= int_stat_reg | int_event;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            int_en_reg <= PMS_IRQ_RST;
        end else if (wr_int_en) begin
            int_en_reg <= bus_req.wdata[PMS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(int_stat_reg & int_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_data_reg <= '0;
        end else if (!bus_req.rd) begin
            rd_data_reg <= '0;
        end else if (bus_req.addr == PMS_OFS_MODE) begin
            rd_data_reg <= {{(PMS_DATA_W-PMS_MODE_W){1'b0}}, mode_reg};
        end else if (bus_req.addr == PMS_OFS_CONFIG) begin
            rd_data_reg <= cfg_reg;
        end else if (bus_req.addr == PMS_OFS_MIRROR) begin
            rd_data_reg <= stage_reg;
        end else if (bus_req.addr == PMS_OFS_ACTIVE) begin
            rd_data_reg <= active_reg;
        end else if (bus_req.addr == PMS_OFS_COUNT) begin
            rd_data_reg <= {presc_reg, count_reg};
        end else if (bus_req.addr == PMS_OFS_INT_STAT) begin
            rd_data_reg <= {{(PMS_DATA_W-PMS_IRQ_W){1'b0}}, int_stat_reg};
        end else if (bus_req.addr == PMS_OFS_INT_EN) begin
            rd_data_reg <= {{(PMS_DATA_W-PMS_IRQ_W){1'b0}}, int_en_reg};
        end else begin
            rd_data_reg <= '0;
        end
    end

    // Count output registered so it leaves straight from a flop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pwm_count <= '0;
        end else begin
            pwm_count <= count_reg;
        end
    end

    assign rd_data  = rd_data_reg;
    assign sync_out = sync_out_reg;
    assign irq      = irq_reg;

endmodule

/* File: tb/pms_mode_shadow_sva.sv */
// Checker for the PWM mode and shadow block, bound to its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pms_mode_shadow_sva
    import pms_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  sys_rst,
    input wire pms_bus_req_type       bus_req,
    input wire logic [PMS_DATA_W-1:0] rd_data,
    input wire logic                  sync_in_pin,
    input wire logic                  trans_enable_pin,
    input wire logic                  sync_out,
    input wire logic                  irq,
    input wire logic [PMS_CNT_W-1:0]  pwm_count
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Last mode value written by software; hardware only clears bits 0, 6, 7
    logic [PMS_MODE_W-1:0] mode_w_reg;
    logic [2:0]            age_reg;
    logic                  touched_reg;
    logic                  mode_wr;
    assign mode_wr = bus_req.wr && bus_req.addr == PMS_OFS_MODE;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_w_reg <= PMS_MODE_RST;
            age_reg <= 3'h7;
            touched_reg <= 1'b0;
        end else if (mode_wr) begin
            mode_w_reg <= bus_req.wdata[PMS_MODE_W-1:0];
            age_reg <= 3'h0;
            touched_reg <= 1'b1;
        end else if (age_reg != 3'h7) begin
            age_reg <= age_reg + 3'h1;
        end
    end
    sequence mode_rd_s;
        $past(bus_req.rd) && $past(bus_req.addr) == PMS_OFS_MODE;
    endsequence
    sequence idle_s;
        !mode_w_reg[PMS_B_COUNTER_RUN] && !mode_w_reg[PMS_B_COUNTER_CLEAR];
    endsequence
    a_run_stops: assert property (idle_s [*3] |-> pwm_count == $past(pwm_count))
        else $error("counter moved while stopped");
    a_clear_zero: assert property (mode_wr && bus_req.wdata[1] |-> ##[1:3] pwm_count == '0)
        else $error("clear did not zero the counter");
    a_clear_holds: assert property (mode_w_reg[PMS_B_COUNTER_CLEAR] [*3] |-> pwm_count == '0)
        else $error("counter left zero under clear");
    a_sync_self_clears: assert property (mode_rd_s ##0 $past(age_reg) >= 3'h4
        |-> rd_data[PMS_B_DOMAIN_SYNC] == 1'b0)
        else $error("domain sync bit not cleared");
    a_source_reset_internal: assert property (mode_rd_s ##0 !$past(touched_reg)
        |-> rd_data == '0)
        else $error("mode reset value wrong");
    a_gate_holds_low: assert property (!mode_w_reg[PMS_B_SYNC_OUT_GATE] [*3] |-> !sync_out)
        else $error("sync output active while gated");
    a_pin_new_cycle: assert property ($rose(sync_in_pin) && mode_w_reg[3]
        && mode_w_reg[4] && !mode_w_reg[1] && !mode_w_reg[2] |-> ##[1:6] sync_out)
        else $error("sync pin gave no new cycle");
    a_read_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == '0)
        else $error("read data outside read slot");
endmodule
bind pms_mode_shadow pms_mode_shadow_sva u_sva (.clock(clock), .sys_rst(sys_rst),
    .bus_req(bus_req), .rd_data(rd_data), .sync_in_pin(sync_in_pin),
    .trans_enable_pin(trans_enable_pin), .sync_out(sync_out), .irq(irq),
    .pwm_count(pwm_count));

/* File: tb/pms_neighbour.sv */
// Model of a neighbouring PWM unit driving the sync and transfer pins.
// Assumes the bench commands it; outputs change just after clock edges.
`timescale 1ns/1ps
module pms_neighbour (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic pulse_req,
    input  wire logic hold_req,
    output logic      sync_pin,
    output logic      xfer_pin
);
    logic [1:0] left_reg;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            left_reg <= 2'h0;
            sync_pin <= 1'b0;
            xfer_pin <= 1'b0;
        end else begin
            xfer_pin <= hold_req;
            sync_pin <= pulse_req || left_reg != 2'h0;
            if (pulse_req) begin
                left_reg <= 2'h3;
            end else if (left_reg != 2'h0) begin
                left_reg <= left_reg - 2'h1;
            end
        end
    end
endmodule

/* File: tb/pms_mode_shadow_tb_top.sv */
// Self-checking bench for the PWM mode and shadow block.
// Assumes the neighbour model drives the sync and transfer pins.
`timescale 1ns/1ps
module pms_mode_shadow_tb_top;
    import pms_pkg::*;
    logic                  clock = 1'b0;
    logic                  sys_rst = 1'b1;
    pms_bus_req_type       bus = '0;
    logic [PMS_DATA_W-1:0] rd_data;
    logic                  pulse_req = 1'b0;
    logic                  hold_req = 1'b0;
    logic                  sync_in_pin;
    logic                  trans_enable_pin;
    logic                  sync_out;
    logic                  irq;
    logic [PMS_CNT_W-1:0]  pwm_count;
    logic [PMS_CNT_W-1:0]  snap;
    int                    fails = 0;
    int                    checked = 0;
    int                    outs = 0;
    pms_mode_shadow DUT (.clock(clock), .sys_rst(sys_rst), .bus_req(bus), .rd_data(rd_data),
        .sync_in_pin(sync_in_pin), .trans_enable_pin(trans_enable_pin),
        .sync_out(sync_out), .irq(irq), .pwm_count(pwm_count));
    pms_neighbour NB (.clock(clock), .sys_rst(sys_rst), .pulse_req(pulse_req),
        .hold_req(hold_req), .sync_pin(sync_in_pin), .xfer_pin(trans_enable_pin));
    initial begin
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        if (sync_out === 1'b1) outs++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] m,
                              input logic [31:0] exp);
        @(posedge clock);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 chk(what, rd_data & m, exp);
    endtask
    task automatic pulse();
        @(posedge clock);
        pulse_req <= 1'b1;
        @(posedge clock);
        pulse_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        expect_reg("mode", PMS_OFS_MODE, 32'hFFFFFFFF, 32'h00000000);
        expect_reg("config", PMS_OFS_CONFIG, 32'hFFFFFFFF, 32'h0000FFFF);
        expect_reg("unmapped", 8'h40, 32'hFFFFFFFF, 32'h00000000);
        chk("irq", irq, 32'h0);
    endtask
    task automatic t_run_clear();
        wr(PMS_OFS_MODE, 32'h00000001);
        idle(4);
        snap = pwm_count;
        idle(1);
        chk("count step", pwm_count, snap + 16'h1);
        wr(PMS_OFS_MODE, 32'h00000000);
        idle(3);
        snap = pwm_count;
        idle(4);
        chk("count stopped", pwm_count, snap);
        wr(PMS_OFS_MODE, 32'h00000003);
        idle(8);
        chk("count cleared", pwm_count, 32'h0);
    endtask
    task automatic t_domain_sync(input logic [31:0] cfg, input logic [31:0] en);
        wr(PMS_OFS_INT_EN, en);
        wr(PMS_OFS_CONFIG, cfg);
        wr(PMS_OFS_MODE, 32'h00000080);
        idle(5);
        expect_reg("sync bit", PMS_OFS_MODE, 32'h00000080, 32'h0);
        expect_reg("mirror", PMS_OFS_MIRROR, 32'hFFFFFFFF, cfg);
        expect_reg("sync done", PMS_OFS_INT_STAT, 32'h00000002, 32'h2);
        chk("irq level", irq, {31'h0, en[1]});
        wr(PMS_OFS_INT_CLR, 32'h00000007);
        idle(2);
        chk("irq cleared", irq, 32'h0);
    endtask
    task automatic t_sw_transfer();
        wr(PMS_OFS_MODE, 32'h00000051);
        idle(3);
        pulse();
        idle(8);
        expect_reg("active", PMS_OFS_ACTIVE, 32'hFFFFFFFF, 32'h00000005);
        expect_reg("sw bit", PMS_OFS_MODE, 32'h00000040, 32'h0);
        expect_reg("xfer done", PMS_OFS_INT_STAT, 32'h00000001, 32'h1);
    endtask
    task automatic t_single_cycle();
        wr(PMS_OFS_MODE, 32'h00000003);
        wr(PMS_OFS_MODE, 32'h00000005);
        idle(20);
        expect_reg("run once", PMS_OFS_MODE, 32'hFFFFFFFF, 32'h00000004);
        expect_reg("stopped", PMS_OFS_COUNT, 32'hFFFFFFFF, 32'h00000000);
    endtask
    task automatic t_hw_transfer();
        t_domain_sync(32'h00000009, 32'h00000000);
        wr(PMS_OFS_MODE, 32'h00000020);
        hold_req <= 1'b1;
        idle(8);
        expect_reg("pin ignored", PMS_OFS_ACTIVE, 32'hFFFFFFFF, 32'h5);
        wr(PMS_OFS_MODE, 32'h00000030);
        idle(6);
        expect_reg("hw load", PMS_OFS_ACTIVE, 32'hFFFFFFFF, 32'h9);
        hold_req <= 1'b0;
    endtask
    task automatic t_sync_out();
        // Counter stopped, so only the pin can start a new cycle
        wr(PMS_OFS_MODE, 32'h00000018);
        outs = 0;
        pulse();
        idle(10);
        chk("sync out count", 32'(outs), 32'h4);
        wr(PMS_OFS_MODE, 32'h00000011);
        idle(3);
        outs = 0;
        pulse();
        idle(10);
        chk("sync out gated", 32'(outs), 32'h0);
    endtask
    initial begin
        idle(10);
        sys_rst <= 1'b0;
        t_reset_values();
        t_run_clear();
        t_domain_sync(32'h00000005, 32'h00000002);
        t_sw_transfer();
        t_single_cycle();
        t_hw_transfer();
        t_sync_out();
        close_out();
    end
    initial begin
        #20000;
        fails++;
        close_out();
    end
endmodule
